/* hw/pwm_ctl_if.sv */
// control and output bundle between the timer top and the three-channel generator
interface pwm_ctl_if #(
   parameter int W = 14,
   parameter int N = 3
);
   logic              enable;
   logic              pause;
   logic              tick;
   logic [W-1:0]      period;
   logic [N-1:0][W-1:0] duty;
   logic [N-1:0]      outs;

   modport ctl (output enable, output pause, output tick, output period, output duty,
                input outs);
   modport gen (input enable, input pause, input tick, input period, input duty,
                output outs);
endinterface

/* hw/timer_and_triple_pwm.sv */
// general purpose timer with phase pwm plus a three-channel pwm unit
//
// Contract
// - with output style 0 the timer pwm output is steady high for the whole high phase.
// - with output style 1 the output carries the fast clock divided by two in the high phase.
// - divider bit 1 runs the on-counter on the selected clock, bit 0 on that clock over ten.
// - clock select 1 counts on the fast clock, 0 on the 32 kHz slow clock.
// - run bit 0 stops the timer and holds it in reset, run bit 1 lets it count.
// - writes to the on register set its reload value, reads return the live on-counter.
// - writes to the high register set the high reload, reads return the live phase counter.
// - writes to the low register set the low reload, reads return the live phase counter.
// - the three-channel unit drives its outputs only while its enable bit is 1.
// - the software pause bit pauses all three channels.
// - while the hardware pause allow bit is 1 (its reset value) a hardware request pauses them.
// - a 1 written to freeze-set halts the timer, a 1 to freeze-clear resumes it, 0 is ignored.
module timer_and_triple_pwm
   import timer_pwm_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic                reset,
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic [DATA_W-1:0]   reg_wdata,
   input  wire logic                reg_write,
   input  wire logic                reg_read,
   output logic      [DATA_W-1:0]   reg_rdata,
   input  wire logic                slow_clk_in,
   input  wire logic                fast_clk_in,
   input  wire logic                hw_pause_req,
   output logic                     timer_pwm_out,
   output logic                     timer_pwm_out_n,
   output logic                     on_count_zero,
   output logic      [CHANNELS-1:0] channel_pwm_out
);

   // register state
   logic [CTL_W-1:0]              control_q;
   logic [DATA_W-1:0]             on_reload_value_q;
   logic [DATA_W-1:0]             high_reload_value_q;
   logic [DATA_W-1:0]             low_reload_value_q;
   logic [CHANNELS-1:0][PWM_W-1:0] duty_q;
   logic [PWM_W-1:0]              period_q;
   logic [TRI_W-1:0]              triple_ctrl_q;
   logic                          freeze_q;
   logic [DATA_W-1:0]             rdata_q;

   // pin synchronisers and edge detect
   logic [2:0] slow_sync_q;
   logic [2:0] fast_sync_q;
   logic [1:0] pause_sync_q;
   logic       slow_tick;
   logic       fast_tick;

   // timer state
   phase_t      phase_q;
   logic [DATA_W-1:0] on_counter_q;
   logic [DATA_W-1:0] high_low_counter_q;
   logic [3:0]  prescale_q;
   logic        half_rate_q;
   logic        on_zero_q;
   logic        pwm_q;
   logic        pwm_n_q;
   logic        chan_tick_q;

   // decoded controls
   logic timer_run;
   logic fast_clock_select;
   logic on_counter_divider_bypass;
   logic output_style;
   logic three_channel_enable;
   logic software_pause;
   logic hardware_pause_allow;
   logic timer_tick;
   logic on_tick;
   logic counting;

   assign timer_run                 = control_q[CTL_RUN_BIT];
   assign fast_clock_select         = control_q[CTL_FAST_BIT];
   assign on_counter_divider_bypass = control_q[CTL_BYPASS_BIT];
   assign output_style              = control_q[CTL_MODE_BIT];
   assign three_channel_enable      = triple_ctrl_q[TRI_ENABLE_BIT];
   assign software_pause            = triple_ctrl_q[TRI_SWPAUSE_BIT];
   assign hardware_pause_allow      = triple_ctrl_q[TRI_HWALLOW_BIT];

   // two flops on each pin, the third flop only feeds the edge detect
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         slow_sync_q  <= 3'h0;
         fast_sync_q  <= 3'h0;
         pause_sync_q <= 2'h0;
      end else begin
         slow_sync_q  <= {slow_sync_q[1:0], slow_clk_in};
         fast_sync_q  <= {fast_sync_q[1:0], fast_clk_in};
         pause_sync_q <= {pause_sync_q[0], hw_pause_req};
      end
   end

   // rising edges of the sampled clocks; fast clock must stay below half of ref_clk
   assign slow_tick  = slow_sync_q[1] && !slow_sync_q[2];
   assign fast_tick  = fast_sync_q[1] && !fast_sync_q[2];
   assign timer_tick = fast_clock_select ? fast_tick : slow_tick;
   assign counting   = timer_run && !freeze_q;
   // on-counter sees every tick, or every tenth one
   assign on_tick    = timer_tick &&
                       (on_counter_divider_bypass || prescale_q == ON_DIV_LAST);

   // register writes
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         control_q           <= CTL_RESET;
         on_reload_value_q   <= RELOAD_RESET;
         high_reload_value_q <= RELOAD_RESET;
         low_reload_value_q  <= RELOAD_RESET;
         duty_q              <= {CHANNELS{PWM_RESET}};
         period_q            <= PWM_RESET;
         triple_ctrl_q       <= TRI_RESET;
      end else if (reg_write) begin
         unique case (reg_addr)
            ADDR_TIMER_CONTROL: control_q           <= reg_wdata[CTL_W-1:0];
            ADDR_ON_RELOAD:     on_reload_value_q   <= reg_wdata;
            ADDR_HIGH_RELOAD:   high_reload_value_q <= reg_wdata;
            ADDR_LOW_RELOAD:    low_reload_value_q  <= reg_wdata;
            ADDR_DUTY_FIRST:    duty_q[0]           <= reg_wdata[PWM_W-1:0];
            ADDR_DUTY_SECOND:   duty_q[1]           <= reg_wdata[PWM_W-1:0];
            ADDR_DUTY_THIRD:    duty_q[2]           <= reg_wdata[PWM_W-1:0];
            ADDR_PERIOD:        period_q            <= reg_wdata[PWM_W-1:0];
            ADDR_TRIPLE_CTRL:   triple_ctrl_q       <= reg_wdata[TRI_W-1:0];
            default: ;
         endcase
      end
   end

   // freeze flag: only a written one acts, zeros are dropped
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         freeze_q <= 1'b0;
      end else if (reg_write && reg_wdata[FREEZE_TIMER_BIT]) begin
         if (reg_addr == ADDR_FREEZE_SET) begin
            freeze_q <= 1'b1;
         end else if (reg_addr == ADDR_FREEZE_CLEAR) begin
            freeze_q <= 1'b0;
         end
      end
   end

   // read data one cycle after the strobe; counters read live
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rdata_q <= '0;
      end else if (reg_read) begin
         rdata_q <= '0;
         unique case (reg_addr)
            ADDR_TIMER_CONTROL: rdata_q[CTL_W-1:0] <= control_q;
            ADDR_ON_RELOAD:     rdata_q <= on_counter_q;
            ADDR_HIGH_RELOAD:   rdata_q <= high_low_counter_q;
            ADDR_LOW_RELOAD:    rdata_q <= high_low_counter_q;
            ADDR_DUTY_FIRST:    rdata_q[PWM_W-1:0] <= duty_q[0];
            ADDR_DUTY_SECOND:   rdata_q[PWM_W-1:0] <= duty_q[1];
            ADDR_DUTY_THIRD:    rdata_q[PWM_W-1:0] <= duty_q[2];
            ADDR_PERIOD:        rdata_q[PWM_W-1:0] <= period_q;
            ADDR_TRIPLE_CTRL:   rdata_q[TRI_W-1:0] <= triple_ctrl_q;
            ADDR_FREEZE_SET,
            ADDR_FREEZE_CLEAR:  rdata_q[FREEZE_TIMER_BIT] <= freeze_q;
            default: ;
         endcase
      end
   end

   // divide-by-ten prescale for the on-counter only
   always_ff @(posedge ref_clk) begin
      if (reset || !timer_run) begin
         prescale_q <= 4'h0;
      end else if (counting && timer_tick) begin
         prescale_q <= (prescale_q == ON_DIV_LAST) ? 4'h0 : prescale_q + 4'h1;
      end
   end

   // on-counter counts down and reloads at zero with a one-cycle marker
   always_ff @(posedge ref_clk) begin
      if (reset || !timer_run) begin
         on_counter_q <= RELOAD_RESET;
         on_zero_q    <= 1'b0;
      end else if (phase_q == PHASE_IDLE) begin
         on_counter_q <= on_reload_value_q;
         on_zero_q    <= 1'b0;
      end else if (counting && on_tick) begin
         on_zero_q <= (on_counter_q == '0);
         if (on_counter_q == '0) begin
            on_counter_q <= on_reload_value_q;
         end else begin
            on_counter_q <= on_counter_q - DATA_W'(1);
         end
      end else begin
         on_zero_q <= 1'b0;
      end
   end

   // high/low phase machine, the undivided tick drives it
   always_ff @(posedge ref_clk) begin
      if (reset || !timer_run) begin
         phase_q            <= PHASE_IDLE;
         high_low_counter_q <= RELOAD_RESET;
      end else if (counting) begin
         unique case (phase_q)
            PHASE_IDLE: begin
               phase_q            <= PHASE_HIGH;
               high_low_counter_q <= high_reload_value_q;
            end
            PHASE_HIGH: begin
               if (timer_tick) begin
                  if (high_low_counter_q == '0) begin
                     phase_q            <= PHASE_LOW;
                     high_low_counter_q <= low_reload_value_q;
                  end else begin
                     high_low_counter_q <= high_low_counter_q - DATA_W'(1);
                  end
               end
            end
            PHASE_LOW: begin
               if (timer_tick) begin
                  if (high_low_counter_q == '0) begin
                     phase_q            <= PHASE_HIGH;
                     high_low_counter_q <= high_reload_value_q;
                  end else begin
                     high_low_counter_q <= high_low_counter_q - DATA_W'(1);
                  end
               end
            end
            default: begin
               phase_q            <= PHASE_IDLE;
               high_low_counter_q <= RELOAD_RESET;
            end
         endcase
      end
   end

   // fast clock halved; restarts high at every high phase so the burst starts clean
   always_ff @(posedge ref_clk) begin
      if (reset || phase_q != PHASE_HIGH) begin
         half_rate_q <= 1'b1;
      end else if (fast_tick && !freeze_q) begin
         half_rate_q <= !half_rate_q;
      end
   end

   // timer pwm outputs, both low while stopped
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pwm_q   <= 1'b0;
         pwm_n_q <= 1'b0;
      end else begin
         pwm_q   <= (phase_q == PHASE_HIGH) && (!output_style || half_rate_q);
         pwm_n_q <= (phase_q == PHASE_LOW);
      end
   end

   // three-channel unit counts on fast clock edges
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         chan_tick_q <= 1'b0;
      end else begin
         chan_tick_q <= fast_tick;
      end
   end

   pwm_ctl_if #(.W(PWM_W), .N(CHANNELS)) chan_bus ();

   assign chan_bus.enable = three_channel_enable;
   assign chan_bus.pause  = software_pause ||
                            (hardware_pause_allow && pause_sync_q[1]);
   assign chan_bus.tick   = chan_tick_q;
   assign chan_bus.period = period_q;
   assign chan_bus.duty   = duty_q;

   triple_pwm #(.W(PWM_W), .N(CHANNELS)) u_triple (
      .ref_clk (ref_clk),
      .reset   (reset),
      .bus     (chan_bus)
   );

   assign reg_rdata       = rdata_q;
   assign timer_pwm_out   = pwm_q;
   assign timer_pwm_out_n = pwm_n_q;
   assign on_count_zero   = on_zero_q;
   assign channel_pwm_out = chan_bus.outs;

endmodule

/* hw/timer_pwm_pkg.sv */
// shared constants and types for the timer and three-channel pwm block
package timer_pwm_pkg;

   // register byte addresses as printed
   localparam logic [31:0] ADDR_FREEZE_SET    = 32'h5000_3300;
   localparam logic [31:0] ADDR_FREEZE_CLEAR  = 32'h5000_3302;
   localparam logic [31:0] ADDR_TIMER_CONTROL = 32'h5000_3400;
   localparam logic [31:0] ADDR_ON_RELOAD     = 32'h5000_3402;
   localparam logic [31:0] ADDR_HIGH_RELOAD   = 32'h5000_3404;
   localparam logic [31:0] ADDR_LOW_RELOAD    = 32'h5000_3406;
   localparam logic [31:0] ADDR_DUTY_FIRST    = 32'h5000_3408;
   localparam logic [31:0] ADDR_DUTY_SECOND   = 32'h5000_340A;
   localparam logic [31:0] ADDR_DUTY_THIRD    = 32'h5000_340C;
   localparam logic [31:0] ADDR_PERIOD        = 32'h5000_340E;
   localparam logic [31:0] ADDR_TRIPLE_CTRL   = 32'h5000_3410;

   // widths
   localparam int DATA_W    = 16;
   localparam int ADDR_W    = 32;
   localparam int PWM_W     = 14;
   localparam int CHANNELS  = 3;

   // timer control field positions
   localparam int CTL_RUN_BIT     = 0;
   localparam int CTL_FAST_BIT    = 1;
   localparam int CTL_BYPASS_BIT  = 2;
   localparam int CTL_MODE_BIT    = 3;
   localparam int CTL_W           = 4;

   // three-channel control field positions
   localparam int TRI_ENABLE_BIT  = 0;
   localparam int TRI_SWPAUSE_BIT = 1;
   localparam int TRI_HWALLOW_BIT = 2;
   localparam int TRI_W           = 3;

   // freeze register field position for this timer
   localparam int FREEZE_TIMER_BIT = 1;

   // reset values
   localparam logic [CTL_W-1:0]  CTL_RESET    = 4'h0;
   localparam logic [TRI_W-1:0]  TRI_RESET    = 3'h4;
   localparam logic [DATA_W-1:0] RELOAD_RESET = 16'h0000;
   localparam logic [PWM_W-1:0]  PWM_RESET    = 14'h0000;

   // on-counter prescale when the divider is not bypassed
   localparam int            ON_DIVIDE   = 10;
   localparam logic [3:0]    ON_DIV_LAST = 4'(ON_DIVIDE - 1);

   // timer phase, one-hot
   typedef enum logic [2:0] {
      PHASE_IDLE = 3'b001,
      PHASE_HIGH = 3'b010,
      PHASE_LOW  = 3'b100
   } phase_t;

endpackage

/* hw/triple_pwm.sv */
// three pwm channels sharing one period counter
module triple_pwm
   import timer_pwm_pkg::*;
#(
   parameter int W = PWM_W,
   parameter int N = CHANNELS
) (
   input wire logic ref_clk,
   input wire logic reset,
   pwm_ctl_if.gen   bus
);

   logic [W-1:0] count_q;
   logic [N-1:0] outs_q;

   // refuse sizes the counter and compare cannot serve
   if (W < 1 || N < 1) begin : g_bad_size
      $error("triple_pwm: bad width or channel count");
   end

   // shared period counter, held at zero when disabled and frozen while paused
   always_ff @(posedge ref_clk) begin
      if (reset || !bus.enable) begin
         count_q <= '0;
      end else if (bus.tick && !bus.pause) begin
         if (count_q >= bus.period) begin
            count_q <= '0;
         end else begin
            count_q <= count_q + W'(1);
         end
      end
   end

   // per channel compare; paused or disabled channels sit low
   for (genvar i = 0; i < N; i++) begin : g_chan
      always_ff @(posedge ref_clk) begin
         if (reset) begin
            outs_q[i] <= 1'b0;
         end else begin
            outs_q[i] <= bus.enable && !bus.pause && (count_q < bus.duty[i]);
         end
      end
   end

   assign bus.outs = outs_q;

endmodule

/* testbench/pin_side_model.sv */
// far side of the pins: free running pin clocks in, a pulse counting load out
module pin_side_model (
   output logic      fast_clk_in,
   output logic      slow_clk_in,
   input  wire logic timer_pwm_out,
   output int        rise_count
);
   timeunit 1ns;
   timeprecision 1ps;

   // crystal oscillators run free, unrelated in phase to ref_clk
   initial begin
      fast_clk_in = 1'h0;
      forever #31.25 fast_clk_in = ~fast_clk_in;
   end
   initial begin
      slow_clk_in = 1'h0;
      forever #15625 slow_clk_in = ~slow_clk_in;
   end

   // the load only tallies the pulses it receives
   initial rise_count = 0;
   always @(posedge timer_pwm_out) rise_count++;
endmodule

/* testbench/test_timer_and_triple_pwm.sv */
// register level tests of the timer and three-channel pwm block
module test_timer_and_triple_pwm
   import timer_pwm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic                ref_clk, reset, reg_write, reg_read, hw_pause_req;
   logic [ADDR_W-1:0]   reg_addr;
   logic [DATA_W-1:0]   reg_wdata, reg_rdata;
   logic                slow_clk_in, fast_clk_in, timer_pwm_out, timer_pwm_out_n, on_count_zero;
   logic [CHANNELS-1:0] channel_pwm_out;
   int                  bad_count, tests_run, rise_count, zero_cnt;
   int                  hi_cnt [CHANNELS];
   localparam logic [ADDR_W-1:0] MAP_A [12] = '{ADDR_FREEZE_SET, ADDR_FREEZE_CLEAR,
      ADDR_TIMER_CONTROL, ADDR_ON_RELOAD, ADDR_HIGH_RELOAD, ADDR_LOW_RELOAD, ADDR_DUTY_FIRST,
      ADDR_DUTY_SECOND, ADDR_DUTY_THIRD, ADDR_PERIOD, ADDR_TRIPLE_CTRL, 32'h5000_3420};

   timer_and_triple_pwm uut (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
      .reg_rdata, .slow_clk_in, .fast_clk_in, .hw_pause_req, .timer_pwm_out,
      .timer_pwm_out_n, .on_count_zero, .channel_pwm_out);
   pin_side_model load (.fast_clk_in, .slow_clk_in, .timer_pwm_out, .rise_count);

   initial begin
      ref_clk = 1'h0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // high-cycle tallies over a measuring span
   always @(posedge ref_clk) begin
      for (int i = 0; i < CHANNELS; i++) hi_cnt[i] += int'(channel_pwm_out[i]);
      zero_cnt += int'(on_count_zero);
   end

   task automatic check(input string n, input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask

   // leading edge keeps strobe clears and raises in different time steps
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'h1;
      @(posedge ref_clk);
      reg_write <= 1'h0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'h1;
      @(posedge ref_clk);
      reg_read <= 1'h0;
      #1;
      d = reg_rdata;
   endtask

   task automatic span(input int n);
      @(posedge ref_clk);
      hi_cnt = '{default: 0};
      zero_cnt = 0;
      repeat (n) @(posedge ref_clk);
   endtask

   // skips the first run at a level, cut short by a restart, then times the next full one
   task automatic run_len(input logic lvl, output int n);
      for (int k = 0; k < 4; k++) begin
         n = 0;
         while ((timer_pwm_out === lvl) == (k % 2 == 1) && n < 500) begin
            @(posedge ref_clk);
            #1 n++;
         end
      end
   endtask

   task automatic complete_run();
      if (bad_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // the whole sequence needs well under 20000 cycles
   initial begin
      #200us;
      bad_count++;
      complete_run();
   end

   initial begin
      logic [DATA_W-1:0] v, w;
      int                n, r0;
      {reg_addr, reg_wdata, reg_write, reg_read, hw_pause_req} = '0;
      reset = 1'h1;
      repeat (8) @(posedge ref_clk);
      reset <= 1'h0;
      for (int i = 0; i < 12; i++) begin
         rd(MAP_A[i], v);
         check("reset value", v, (i == 10) ? 16'h0004 : 16'h0000);
      end
      for (int i = 6; i < 12; i++) begin
         wr(MAP_A[i], 16'hFFFF);
         rd(MAP_A[i], v);
         check("field width", v, (i == 10) ? 16'h0007 : (i == 11) ? 16'h0000 : 16'h3FFF);
      end
      // period of ten counts; duties 0, half and above the period
      wr(ADDR_PERIOD, 16'h0009);
      for (int k = 0; k < CHANNELS; k++) wr(MAP_A[6+k], 16'(5 * k));
      wr(ADDR_TRIPLE_CTRL, 16'h0000);
      span(200);
      check("disabled", 16'(hi_cnt[2]), 16'h0000);
      wr(ADDR_TRIPLE_CTRL, 16'h0001);
      span(1250);
      check("duty zero", 16'(hi_cnt[0]), 16'h0000);
      check("duty half", 16'(hi_cnt[1] >= 600 && hi_cnt[1] <= 650), 16'h0001);
      check("duty full", 16'(hi_cnt[2] >= 1220), 16'h0001);
      wr(ADDR_TRIPLE_CTRL, 16'h0003);
      span(200);
      check("software pause", 16'(hi_cnt[2] <= 5), 16'h0001);
      hw_pause_req <= 1'h1;
      wr(ADDR_TRIPLE_CTRL, 16'h0005);
      span(200);
      check("hardware pause", 16'(hi_cnt[2] <= 6), 16'h0001);
      wr(ADDR_TRIPLE_CTRL, 16'h0001);
      span(200);
      check("hardware not allowed", 16'(hi_cnt[2] >= 190), 16'h0001);
      hw_pause_req <= 1'h0;
      // fast clock, level style, divider bypassed
      wr(ADDR_HIGH_RELOAD, 16'h0003);
      wr(ADDR_LOW_RELOAD, 16'h0005);
      wr(ADDR_ON_RELOAD, 16'h0100);
      wr(ADDR_TIMER_CONTROL, 16'h0007);
      run_len(1'h1, n);
      check("high length", 16'(n >= 47 && n <= 53), 16'h0001);
      check("low phase marker", {15'h0, timer_pwm_out_n}, 16'h0001);
      rd(ADDR_HIGH_RELOAD, v);
      check("live low count", 16'(v >= 4 && v <= 5), 16'h0001);
      run_len(1'h0, n);
      check("low length", 16'(n >= 72 && n <= 78), 16'h0001);
      rd(ADDR_LOW_RELOAD, v);
      check("live high count", 16'(v <= 3), 16'h0001);
      rd(ADDR_ON_RELOAD, v);
      repeat (247) @(posedge ref_clk);
      rd(ADDR_ON_RELOAD, w);
      check("on count moves", 16'(v < 16'h0100 && v - w >= 18 && v - w <= 22), 16'h0001);
      // on-counter zero pulses with and without the divide by ten
      wr(ADDR_TIMER_CONTROL, 16'h0000);
      wr(ADDR_ON_RELOAD, 16'h0004);
      wr(ADDR_TIMER_CONTROL, 16'h0007);
      span(1250);
      check("undivided", 16'(zero_cnt >= 18 && zero_cnt <= 22), 16'h0001);
      wr(ADDR_TIMER_CONTROL, 16'h0003);
      span(1250);
      check("divided", 16'(zero_cnt >= 1 && zero_cnt <= 3), 16'h0001);
      // clock style: two rises per high phase of four ticks
      wr(ADDR_TIMER_CONTROL, 16'h0000);
      wr(ADDR_TIMER_CONTROL, 16'h000F);
      r0 = rise_count;
      repeat (1250) @(posedge ref_clk);
      r0 = rise_count - r0;
      check("halved clock", 16'(r0 >= 18 && r0 <= 22), 16'h0001);
      // slow clock hardly moves the on-counter
      wr(ADDR_TIMER_CONTROL, 16'h0000);
      wr(ADDR_ON_RELOAD, 16'h0100);
      wr(ADDR_TIMER_CONTROL, 16'h0005);
      rd(ADDR_ON_RELOAD, v);
      repeat (300) @(posedge ref_clk);
      rd(ADDR_ON_RELOAD, w);
      check("slow clock", 16'(v - w <= 1), 16'h0001);
      // freeze, a zero write that must be ignored, then resume
      wr(ADDR_TIMER_CONTROL, 16'h0000);
      wr(ADDR_TIMER_CONTROL, 16'h0007);
      wr(ADDR_FREEZE_SET, 16'h0002);
      rd(ADDR_FREEZE_SET, v);
      check("frozen flag", v, 16'h0002);
      rd(ADDR_ON_RELOAD, v);
      repeat (200) @(posedge ref_clk);
      rd(ADDR_ON_RELOAD, w);
      check("frozen count", w, v);
      wr(ADDR_FREEZE_CLEAR, 16'h0000);
      rd(ADDR_FREEZE_SET, v);
      check("zero ignored", v, 16'h0002);
      wr(ADDR_FREEZE_CLEAR, 16'h0002);
      rd(ADDR_FREEZE_SET, v);
      check("resumed flag", v, 16'h0000);
      repeat (200) @(posedge ref_clk);
      rd(ADDR_ON_RELOAD, v);
      check("resumed count", 16'(w - v >= 10), 16'h0001);
      wr(ADDR_TIMER_CONTROL, 16'h0000);
      repeat (10) @(posedge ref_clk);
      rd(ADDR_ON_RELOAD, v);
      check("stopped count", v, 16'h0000);
      check("stopped outputs", {14'h0, timer_pwm_out, timer_pwm_out_n}, 16'h0000);
      complete_run();
   end
endmodule

/* testbench/timer_and_triple_pwm_assertions.sv */
// concurrent checks on the pins of the timer and three-channel pwm block
module pwm_pin_checker
   import timer_pwm_pkg::*;
(
   input wire logic                ref_clk,
   input wire logic                reset,
   input wire logic [ADDR_W-1:0]   reg_addr,
   input wire logic [DATA_W-1:0]   reg_wdata,
   input wire logic                reg_write,
   input wire logic                reg_read,
   input wire logic [DATA_W-1:0]   reg_rdata,
   input wire logic                hw_pause_req,
   input wire logic                timer_pwm_out,
   input wire logic                timer_pwm_out_n,
   input wire logic                on_count_zero,
   input wire logic [CHANNELS-1:0] channel_pwm_out
);
   logic [CTL_W-1:0] ctl_q;
   logic [TRI_W-1:0] tri_q;
   logic             frz_q;
   logic [2:0]       off_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   // shadow of the control bits, so checks key on what software asked for
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctl_q <= CTL_RESET;
         tri_q <= TRI_RESET;
      end else if (reg_write && reg_addr == ADDR_TIMER_CONTROL) begin
         ctl_q <= reg_wdata[CTL_W-1:0];
      end else if (reg_write && reg_addr == ADDR_TRIPLE_CTRL) begin
         tri_q <= reg_wdata[TRI_W-1:0];
      end
   end

   // freeze shadow: zeros written to either place change nothing
   always_ff @(posedge ref_clk) begin
      if (reset) frz_q <= 1'h0;
      else if (reg_write && reg_wdata[FREEZE_TIMER_BIT] && reg_addr == ADDR_FREEZE_SET)
         frz_q <= 1'h1;
      else if (reg_write && reg_wdata[FREEZE_TIMER_BIT] && reg_addr == ADDR_FREEZE_CLEAR)
         frz_q <= 1'h0;
   end

   // cycles since run went low, saturating; allows for the register latency
   always_ff @(posedge ref_clk) begin
      if (reset || ctl_q[CTL_RUN_BIT]) off_q <= 3'h0;
      else if (off_q != 3'h7) off_q <= off_q + 3'h1;
   end

   a_rdata_holds: assert property (!reg_read |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_disabled_idle: assert property (
      (!tri_q[TRI_ENABLE_BIT])[*3] |-> channel_pwm_out == '0)
      else $error("channel output while disabled");
   a_sw_paused: assert property (
      tri_q[TRI_SWPAUSE_BIT][*3] |-> channel_pwm_out == '0)
      else $error("channel output while software paused");
   a_hw_paused: assert property (
      (tri_q[TRI_HWALLOW_BIT] && hw_pause_req)[*6] |-> channel_pwm_out == '0)
      else $error("channel output while hardware paused");
   a_stopped_idle: assert property (
      off_q == 3'h7 |-> !timer_pwm_out && !timer_pwm_out_n && !on_count_zero)
      else $error("timer output while stopped");
   // a stop and restart drops the output for two cycles after run is back
   a_level_high: assert property (
      !ctl_q[CTL_MODE_BIT] && $rose(timer_pwm_out) |=>
      (timer_pwm_out || !$past(ctl_q[CTL_RUN_BIT], 2))[*8])
      else $error("level style output dropped early");
   a_half_clock: assert property (
      ctl_q[CTL_MODE_BIT] && ctl_q[CTL_RUN_BIT] && !frz_q && $rose(timer_pwm_out)
      |-> ##[1:16] !timer_pwm_out)
      else $error("clock style output did not toggle");
   a_frozen_hold: assert property (
      frz_q[*4] |-> $stable(timer_pwm_out) && !on_count_zero)
      else $error("timer moved while frozen");
endmodule

bind timer_and_triple_pwm pwm_pin_checker chk (.ref_clk, .reset, .reg_addr, .reg_wdata,
   .reg_write, .reg_read, .reg_rdata, .hw_pause_req, .timer_pwm_out, .timer_pwm_out_n,
   .on_count_zero, .channel_pwm_out);
